// ===== bench/egr_sink.sv
// Purpose: egress transmit path model, accepts descriptors
// Assumes: ready may stall or alternate every cycle
// Notes:   behavioural, no queue of its own
`timescale 1ns/10ps
module egr_sink (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic stall_in,
    input  wire logic slow_in,
    output logic      egr_ready_out
);
    logic toggle_q;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= ~toggle_q;
        end
    end

    // slow mode takes only every second cycle
    assign egr_ready_out = !stall_in && (!slow_in || toggle_q);
endmodule : egr_sink

// ===== bench/qos_sched_checker.sv
// Purpose: port-level assertions for the qos scheduler
// Assumes: weights 8,4,2,1 from the package
// Notes:   mode tracked from writes to the control word
`timescale 1ns/10ps
module qos_sched_checker
    import qos_pkg::*;
(
    input wire logic              clock_in,
    input wire logic              rst_n_in,
    input wire logic              ce_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [REG_W-1:0]  reg_wdata_in,
    input wire logic              reg_wr_in,
    input wire logic              reg_rd_in,
    input wire logic [REG_W-1:0]  reg_rdata_out,
    input wire logic              ing_valid_in,
    input wire logic              ing_ready_out,
    input wire logic              egr_valid_out,
    input wire logic              egr_ready_in,
    input wire logic [DATA_W-1:0] egr_data_out,
    input wire logic [1:0]        egr_queue_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    logic       strict_q, cfg_wr_q, take, put;
    logic [1:0] last_queue_q;
    logic [6:0] run_q, cnt_q;
    logic [3:0] lim;

    assign take = ce_in && egr_valid_out && egr_ready_in;
    assign put  = ce_in && ing_valid_in && ing_ready_out;
    assign lim  = (egr_queue_out == 2'h3) ? WEIGHT_HIGH : (egr_queue_out == 2'h2) ?
                  WEIGHT_MEDIUM : (egr_queue_out == 2'h1) ? WEIGHT_NORMAL : WEIGHT_LOW;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            strict_q <= 1'b0;
            cfg_wr_q <= 1'b0;
        end else if (ce_in && reg_wr_in) begin
            cfg_wr_q <= 1'b1;
            if (reg_addr_in == OFF_CTRL) begin
                strict_q <= reg_wdata_in[CTRL_STRICT_BIT];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_q + 7'(put) - 7'(take);
        end
    end

    // run of back-to-back grants of one queue, cleared by a bubble
    always_ff @(posedge clock_in) begin
        if (!rst_n_in ||
            (ce_in && (!egr_valid_out || (reg_wr_in && reg_addr_in == OFF_CTRL)))) begin
            run_q <= 7'h00;
        end else if (take) begin
            run_q <= (egr_queue_out == last_queue_q) ? run_q + 7'h01 : 7'h01;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            last_queue_q <= 2'h0;
        end else if (take) begin
            last_queue_q <= egr_queue_out;
        end
    end

    property p_wfq_burst;
        take && !strict_q && egr_queue_out == last_queue_q |-> run_q < 7'(lim);
    endproperty
    a_wfq_burst: assert property (p_wfq_burst) else $error("weight exceeded");

    property p_egr_hold;
        egr_valid_out && !egr_ready_in && ce_in |=>
            egr_valid_out && $stable(egr_data_out) && $stable(egr_queue_out);
    endproperty
    a_egr_hold: assert property (p_egr_hold) else $error("egress not held");

    property p_rd_idle;
        ce_in && !reg_rd_in |=> reg_rdata_out == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

    property p_unmapped;
        ce_in && reg_rd_in && reg_addr_in == 8'h40 |=> reg_rdata_out == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");

    property p_map_rst;
        ce_in && reg_rd_in && reg_addr_in == OFF_TAG_MAP && !cfg_wr_q |=>
            reg_rdata_out == 32'h0000_FA41;
    endproperty
    a_map_rst: assert property (p_map_rst) else $error("tag map reset wrong");

    property p_def_rst;
        ce_in && reg_rd_in && reg_addr_in == OFF_DEF_PRIO && !cfg_wr_q |=>
            reg_rdata_out == 32'h0000_5555;
    endproperty
    a_def_rst: assert property (p_def_rst) else $error("default prio reset wrong");

    property p_ce_ready;
        !ce_in |-> !ing_ready_out;
    endproperty
    a_ce_ready: assert property (p_ce_ready) else $error("ready while frozen");

    property p_occupancy;
        egr_valid_out |-> cnt_q != 7'h00;
    endproperty
    a_occupancy: assert property (p_occupancy) else $error("egress without frame");
endmodule : qos_sched_checker

bind qos_sched qos_sched_checker i_chk (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .ing_valid_in(ing_valid_in), .ing_ready_out(ing_ready_out),
    .egr_valid_out(egr_valid_out), .egr_ready_in(egr_ready_in),
    .egr_data_out(egr_data_out), .egr_queue_out(egr_queue_out)
);

// ===== bench/tb_qos_sched.sv
// Purpose: bench for the qos classifier and egress scheduler
// Assumes: egress sink model on the far side
// Notes:   expected queues from the weights and the default tag table
`timescale 1ns/10ps
module tb_qos_sched
    import qos_pkg::*;
;
    logic              clock_in, rst_n_in, ce_in, reg_wr_in, reg_rd_in;
    logic [ADDR_W-1:0] reg_addr_in;
    logic [REG_W-1:0]  reg_wdata_in, reg_rdata_out, rd_val;
    logic              ing_valid_in, ing_ready_out, ing_tag_present_in, ing_ip_present_in;
    logic [PORT_W-1:0] ing_port_in;
    logic [2:0]        ing_tag_prio_in;
    logic [5:0]        ing_dscp_in;
    logic [DATA_W-1:0] ing_data_in, egr_data_out;
    logic              egr_valid_out, egr_ready_in, stall, slow;
    logic [1:0]        egr_queue_out;
    logic [1:0]        got[$], exp_q[$];
    logic [DATA_W-1:0] got_d[$];
    logic [1:0]        tmap [8] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    int                n_errors = 0, checks_done = 0, t;

    qos_sched i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ing_valid_in(ing_valid_in),
        .ing_ready_out(ing_ready_out), .ing_port_in(ing_port_in),
        .ing_tag_present_in(ing_tag_present_in), .ing_tag_prio_in(ing_tag_prio_in),
        .ing_ip_present_in(ing_ip_present_in), .ing_dscp_in(ing_dscp_in),
        .ing_data_in(ing_data_in), .egr_valid_out(egr_valid_out), .egr_ready_in(egr_ready_in),
        .egr_data_out(egr_data_out), .egr_queue_out(egr_queue_out));
    egr_sink i_sink (.clock_in(clock_in), .rst_n_in(rst_n_in), .stall_in(stall),
        .slow_in(slow), .egr_ready_out(egr_ready_in));

    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        if (rst_n_in && ce_in && egr_valid_out && egr_ready_in) begin
            got.push_back(egr_queue_out);
            got_d.push_back(egr_data_out);
        end
    end

    task automatic give_verdict();
        $display("mismatches=%0d comparisons=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            n_errors++;
        end
    endtask : check

    task automatic hang();
        n_errors++;
        give_verdict();
    endtask : hang

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge clock_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [ADDR_W-1:0] a);
        @(posedge clock_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        // read data stand from the second rising edge until the next rising edge
        @(negedge clock_in);
        rd_val = reg_rdata_out;
    endtask : reg_rd

    task automatic send(input logic [2:0] p, input logic tp, input logic [2:0] tg,
                        input logic ip, input logic [5:0] ds);
        int i;
        @(posedge clock_in);
        ing_valid_in       <= 1'b1;
        ing_port_in        <= p;
        ing_tag_present_in <= tp;
        ing_tag_prio_in    <= tg;
        ing_ip_present_in  <= ip;
        ing_dscp_in        <= ds;
        ing_data_in        <= ing_data_in + 16'h0001;
        for (i = 0; i < 300; i++) begin
            @(posedge clock_in);
            if (ing_ready_out === 1'b1) break;
        end
        ing_valid_in <= 1'b0;
        if (i == 300) hang();
    endtask : send

    task automatic wait_got(input int n);
        for (int i = 0; i < 2000 && got.size() < n; i++) @(posedge clock_in);
        if (got.size() < n) hang();
    endtask : wait_got

    task automatic cls(input logic [2:0] p, input logic tp, input logic [2:0] tg,
                       input logic ip, input logic [5:0] ds, input logic [1:0] e);
        send(p, tp, tg, ip, ds);
        wait_got(1);
        check(32'(got.pop_front()), 32'(e));
        check(32'(got_d.pop_front()), 32'(ing_data_in));
    endtask : cls

    // fill queues while egress stalls, then drain and compare grant order
    task automatic burst(input logic strict, input int n [4]);
        int rem [4];
        int w [4];
        int q, k;
        rem = n;
        w = '{int'(WEIGHT_LOW), int'(WEIGHT_NORMAL), int'(WEIGHT_MEDIUM), int'(WEIGHT_HIGH)};
        stall <= 1'b1;
        for (q = 3; q >= 0; q--) begin
            for (int i = 0; i < n[q]; i++) send(3'h2, 1'b0, 3'h0, 1'b1, {q[1:0], 4'h0});
        end
        if (!strict) begin
            @(posedge clock_in);
            ing_valid_in <= 1'b1;
            ing_dscp_in  <= 6'h30;
            repeat (2) @(posedge clock_in);
            check(32'(ing_ready_out), 32'h0);
            ing_valid_in <= 1'b0;
        end
        while (rem[0] + rem[1] + rem[2] + rem[3] > 0) begin
            for (q = 3; q >= 0; q--) begin
                k = strict ? rem[q] : (rem[q] < w[q] ? rem[q] : w[q]);
                repeat (k) exp_q.push_back(q[1:0]);
                rem[q] -= k;
            end
        end
        slow  <= strict;
        stall <= 1'b0;
        wait_got(exp_q.size());
        foreach (exp_q[i]) check(32'(got[i]), 32'(exp_q[i]));
        got.delete();
        got_d.delete();
        exp_q.delete();
        slow <= 1'b0;
    endtask : burst

    initial begin
        {rst_n_in, reg_wr_in, reg_rd_in, ing_valid_in, ing_tag_present_in} = '0;
        {ing_ip_present_in, stall, slow, ing_port_in, ing_tag_prio_in, ing_dscp_in} = '0;
        {reg_addr_in, reg_wdata_in, ing_data_in} = '0;
        ce_in = 1'b1;
        repeat (5) @(posedge clock_in);
        rst_n_in <= 1'b1;
        reg_rd(OFF_TAG_MAP);
        check(rd_val, 32'h0000_FA41);
        reg_rd(OFF_DEF_PRIO);
        check(rd_val, 32'h0000_5555);
        reg_rd(8'h40);
        check(rd_val, 32'h0000_0000);
        cls(3'h0, 1'b1, 3'h7, 1'b1, 6'h30, Q_NORMAL);
        reg_wr(OFF_TAG_EN, 32'h0000_003A);
        reg_wr(OFF_IP_EN, 32'h0000_003C);
        reg_wr(OFF_TAG_OVER, 32'h0000_0008);
        for (t = 0; t < 8; t++) cls(3'h1, 1'b1, t[2:0], 1'b0, 6'h00, tmap[t]);
        cls(3'h1, 1'b0, 3'h5, 1'b1, 6'h30, Q_NORMAL);
        cls(3'h2, 1'b1, 3'h7, 1'b1, 6'h20, Q_MEDIUM);
        cls(3'h3, 1'b1, 3'h1, 1'b1, 6'h30, Q_LOW);
        cls(3'h4, 1'b1, 3'h1, 1'b1, 6'h30, Q_HIGH);
        reg_wr(OFF_DEF_PRIO, 32'h0000_C555);
        cls(3'h7, 1'b0, 3'h0, 1'b0, 6'h00, Q_HIGH);
        reg_wr(OFF_TAG_MAP, 32'h0000_0000);
        cls(3'h1, 1'b1, 3'h7, 1'b0, 6'h00, Q_LOW);
        @(posedge clock_in);
        ce_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        ce_in <= 1'b1;
        // fresh credits for the weighted burst
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        reg_rd(OFF_STATUS);
        check(rd_val, 32'h0000_00F0);
        reg_wr(OFF_IP_EN, 32'h0000_003C);
        burst(1'b0, '{2, 3, 5, 17});
        reg_wr(OFF_CTRL, 32'h0000_0001);
        burst(1'b1, '{2, 2, 2, 3});
        give_verdict();
    end
endmodule : tb_qos_sched

// ===== rtl/desc_fifo.sv
// Purpose: synchronous fifo for frame descriptors
// Assumes: push and pop in the same cycle allowed when neither side blocks
// Notes:   head word shown while out_valid_out is high
`timescale 1ns/10ps
module desc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_ready_out  = ce_in && (count_q != (PW+1)'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign out_data_out  = mem_q[rd_ptr_q];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = ce_in && out_valid_out && out_ready_in;

    always_ff @(posedge clock_in) begin
        if (ce_in && push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (ce_in) begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule : desc_fifo

// ===== rtl/qos_pkg.sv
// Purpose: shared constants and types for the qos classifier and egress scheduler
// Assumes: one switch clock, descriptor-per-frame interfaces
// Notes:   queue code order low < normal < medium < high
package qos_pkg;

    localparam int PORTS      = 8;
    localparam int QUEUES     = 4;
    localparam int PORT_W     = 3;
    localparam int DATA_W     = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int ADDR_W     = 8;
    localparam int REG_W      = 32;

    typedef enum logic [1:0] {
        Q_LOW    = 2'h0,
        Q_NORMAL = 2'h1,
        Q_MEDIUM = 2'h2,
        Q_HIGH   = 2'h3
    } queue_t;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_TAG_EN   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IP_EN    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_TAG_OVER = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_DEF_PRIO = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_TAG_MAP  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h18;

    // field positions
    localparam int CTRL_STRICT_BIT = 0;
    localparam int STAT_NONEMPTY   = 0;
    localparam int STAT_CREDIT     = 4;
    localparam int STAT_OUT_VALID  = 8;

    // reset values
    localparam logic         CTRL_RST     = 1'b0;
    localparam logic [7:0]   TAG_EN_RST   = 8'h00;
    localparam logic [7:0]   IP_EN_RST    = 8'h00;
    localparam logic [7:0]   TAG_OVER_RST = 8'h00;
    localparam logic [15:0]  DEF_PRIO_RST = 16'h5555;
    // tags 0,3 normal; 1,2 low; 4,5 medium; 6,7 high
    localparam logic [15:0]  TAG_MAP_RST  = 16'hFA41;

    // service weights
    localparam logic [3:0] WEIGHT_HIGH   = 4'h8;
    localparam logic [3:0] WEIGHT_MEDIUM = 4'h4;
    localparam logic [3:0] WEIGHT_NORMAL = 4'h2;
    localparam logic [3:0] WEIGHT_LOW    = 4'h1;

endpackage : qos_pkg

// ===== rtl/qos_sched.sv
// Purpose: ingress priority classifier and egress queue scheduler
// Assumes: one descriptor word per frame, frame fields decoded upstream
// Notes:   registers on a plain strobe port, read data one cycle later
// Functional notes
// - weighted mode serves queues by weights 8,4,2,1
// - weighted mode still lets lower queues through
// - strict mode drains highest non-empty queue first
// - per-port enable uses tag priority field
// - per-port enable uses ip tos/diffserv field
// - both present, select set: tag wins
// - both present, select cleared: ip wins
// - per-port default priority among four queues
// - table maps eight tag values to queues
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module qos_sched
    import qos_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [REG_W-1:0]  reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [REG_W-1:0]  reg_rdata_out,
    input  wire logic              ing_valid_in,
    output logic                   ing_ready_out,
    input  wire logic [PORT_W-1:0] ing_port_in,
    input  wire logic              ing_tag_present_in,
    input  wire logic [2:0]        ing_tag_prio_in,
    input  wire logic              ing_ip_present_in,
    input  wire logic [5:0]        ing_dscp_in,
    input  wire logic [DATA_W-1:0] ing_data_in,
    output logic                   egr_valid_out,
    input  wire logic              egr_ready_in,
    output logic      [DATA_W-1:0] egr_data_out,
    output logic      [1:0]        egr_queue_out
);

    // configuration state
    logic              strict_q;
    logic [PORTS-1:0]  tag_en_q;
    logic [PORTS-1:0]  ip_en_q;
    logic [PORTS-1:0]  tag_over_q;
    logic [15:0]       def_prio_q;
    logic [15:0]       tag_map_q;
    logic [REG_W-1:0]  rdata_q;
    logic [REG_W-1:0]  rdata_d;

    // classification
    logic              tag_use;
    logic              ip_use;
    queue_t            tag_queue;
    queue_t            ip_queue;
    queue_t            def_queue;
    queue_t            class_q_d;

    // queues and scheduling
    logic [QUEUES-1:0] fifo_in_valid;
    logic [QUEUES-1:0] fifo_in_ready;
    logic [QUEUES-1:0] nonempty;
    logic [QUEUES-1:0] pop;
    logic [DATA_W-1:0] head_data [QUEUES];
    logic [QUEUES-1:0] credit;
    logic [QUEUES-1:0] eligible;
    logic [QUEUES-1:0] grant;
    logic              grant_any;
    queue_t            grant_queue;
    logic              slot_free;
    logic              reload;

    logic              out_valid_q;
    logic [DATA_W-1:0] out_data_q;
    logic [1:0]        out_queue_q;

    // register writes
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            strict_q <= CTRL_RST;
        end else if (ce_in && reg_wr_in && reg_addr_in == OFF_CTRL) begin
            strict_q <= reg_wdata_in[CTRL_STRICT_BIT];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tag_en_q   <= TAG_EN_RST;
            ip_en_q    <= IP_EN_RST;
            tag_over_q <= TAG_OVER_RST;
        end else if (ce_in && reg_wr_in) begin
            if (reg_addr_in == OFF_TAG_EN) begin
                tag_en_q <= reg_wdata_in[PORTS-1:0];
            end
            if (reg_addr_in == OFF_IP_EN) begin
                ip_en_q <= reg_wdata_in[PORTS-1:0];
            end
            if (reg_addr_in == OFF_TAG_OVER) begin
                tag_over_q <= reg_wdata_in[PORTS-1:0];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            def_prio_q <= DEF_PRIO_RST;
            tag_map_q  <= TAG_MAP_RST;
        end else if (ce_in && reg_wr_in) begin
            if (reg_addr_in == OFF_DEF_PRIO) begin
                def_prio_q <= reg_wdata_in[15:0];
            end
            if (reg_addr_in == OFF_TAG_MAP) begin
                tag_map_q <= reg_wdata_in[15:0];
            end
        end
    end

    // register reads, zero outside the answer cycle and for unmapped offsets
    always_comb begin
        rdata_d = '0;
        unique case (reg_addr_in)
            OFF_CTRL:     rdata_d[CTRL_STRICT_BIT] = strict_q;
            OFF_TAG_EN:   rdata_d[PORTS-1:0] = tag_en_q;
            OFF_IP_EN:    rdata_d[PORTS-1:0] = ip_en_q;
            OFF_TAG_OVER: rdata_d[PORTS-1:0] = tag_over_q;
            OFF_DEF_PRIO: rdata_d[15:0] = def_prio_q;
            OFF_TAG_MAP:  rdata_d[15:0] = tag_map_q;
            OFF_STATUS: begin
                rdata_d[STAT_NONEMPTY +: QUEUES] = nonempty;
                rdata_d[STAT_CREDIT +: QUEUES]   = credit;
                rdata_d[STAT_OUT_VALID]          = out_valid_q;
            end
            default:      rdata_d = '0;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rdata_q <= '0;
        end else if (ce_in) begin
            rdata_q <= reg_rd_in ? rdata_d : '0;
        end
    end

    assign reg_rdata_out = rdata_q;

    // ingress classification
    assign tag_use   = tag_en_q[ing_port_in] && ing_tag_present_in;
    assign ip_use    = ip_en_q[ing_port_in] && ing_ip_present_in;
    assign tag_queue = queue_t'(tag_map_q[{ing_tag_prio_in, 1'b0} +: 2]);
    // top two class selector bits of the diffserv code give the queue
    assign ip_queue  = queue_t'(ing_dscp_in[5:4]);
    assign def_queue = queue_t'(def_prio_q[{ing_port_in, 1'b0} +: 2]);

    always_comb begin
        if (tag_use && ip_use) begin
            if (tag_over_q[ing_port_in]) begin
                class_q_d = tag_queue;
            end else begin
                class_q_d = ip_queue;
            end
        end else if (tag_use) begin
            class_q_d = tag_queue;
        end else if (ip_use) begin
            class_q_d = ip_queue;
        end else begin
            class_q_d = def_queue;
        end
    end

    always_comb begin
        fifo_in_valid = '0;
        fifo_in_valid[class_q_d] = ing_valid_in;
    end

    // back-pressure from the chosen queue only
    assign ing_ready_out = fifo_in_ready[class_q_d];

    // one queue and one credit counter per priority
    genvar gi;
    generate
        for (gi = 0; gi < QUEUES; gi++) begin : g_queue
            localparam logic [3:0] W = (gi == int'(Q_HIGH))   ? WEIGHT_HIGH :
                                       (gi == int'(Q_MEDIUM)) ? WEIGHT_MEDIUM :
                                       (gi == int'(Q_NORMAL)) ? WEIGHT_NORMAL :
                                                                WEIGHT_LOW;

            desc_fifo #(
                .WIDTH (DATA_W),
                .DEPTH (FIFO_DEPTH)
            ) u_fifo (
                .clock_in      (clock_in),
                .rst_n_in      (rst_n_in),
                .ce_in         (ce_in),
                .in_valid_in   (fifo_in_valid[gi]),
                .in_ready_out  (fifo_in_ready[gi]),
                .in_data_in    (ing_data_in),
                .out_valid_out (nonempty[gi]),
                .out_ready_in  (pop[gi]),
                .out_data_out  (head_data[gi])
            );

            weight_credit #(
                .WEIGHT (W)
            ) u_credit (
                .clock_in       (clock_in),
                .rst_n_in       (rst_n_in),
                .ce_in          (ce_in),
                .reload_in      (reload),
                .take_in        (grant[gi] && !strict_q),
                .has_credit_out (credit[gi])
            );
        end
    endgenerate

    // egress selection
    assign slot_free = !out_valid_q || egr_ready_in;

    always_comb begin
        if (strict_q) begin
            eligible = nonempty;
        end else begin
            eligible = nonempty & credit;
        end
    end

    always_comb begin
        grant_queue = Q_LOW;
        if (eligible[Q_HIGH]) begin
            grant_queue = Q_HIGH;
        end else if (eligible[Q_MEDIUM]) begin
            grant_queue = Q_MEDIUM;
        end else if (eligible[Q_NORMAL]) begin
            grant_queue = Q_NORMAL;
        end else begin
            grant_queue = Q_LOW;
        end
    end

    assign grant_any = slot_free && (eligible != '0);

    always_comb begin
        grant = '0;
        grant[grant_queue] = grant_any;
    end

    assign pop = grant;

    // round ends when no waiting queue has credit left
    assign reload = !strict_q && slot_free && (nonempty != '0) &&
                    ((nonempty & credit) == '0);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            out_valid_q <= 1'b0;
        end else if (ce_in && slot_free) begin
            out_valid_q <= grant_any;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            out_data_q  <= '0;
            out_queue_q <= '0;
        end else if (ce_in && grant_any) begin
            out_data_q  <= head_data[grant_queue];
            out_queue_q <= grant_queue;
        end
    end

    assign egr_valid_out = out_valid_q;
    assign egr_data_out  = out_data_q;
    assign egr_queue_out = out_queue_q;

endmodule : qos_sched

// ===== rtl/weight_credit.sv
// Purpose: per-queue service credit for weighted fair scheduling
// Assumes: take only while credit is left
// Notes:   reload restores the full weight
`timescale 1ns/10ps
module weight_credit #(
    parameter logic [3:0] WEIGHT = 4'h1
) (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    input  wire logic reload_in,
    input  wire logic take_in,
    output logic      has_credit_out
);
    logic [3:0] credit_q;

    assign has_credit_out = (credit_q != 4'h0);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            credit_q <= WEIGHT;
        end else if (ce_in) begin
            if (reload_in) begin
                credit_q <= WEIGHT;
            end else if (take_in && has_credit_out) begin
                credit_q <= credit_q - 4'h1;
            end
        end
    end

endmodule : weight_credit
